// [hdl/auto_reload_pwm_capture_timer.sv]
// Reload timer with PWM output, edge capture and an AXI4-Lite slave.
//
// How it works
// RQ1: Counter counts up on each prescaler tap tick.
// RQ2: Clock source: internal, internal over three, pin.
// RQ3: Seven-bit prescaler, eight taps, divide by 2^n.
// RQ4: Enable cleared freezes counter and prescaler.
// RQ5: Reset clears the counter.
// RQ6: Load window writes counter, reads live count.
// RQ7: Every counter load also clears the prescaler.
// RQ8: Auto-reload: overflow reloads counter, drives output high.
// RQ9: Auto-reload: compare match drives output low.
// RQ10: Overflow sets sticky flag, maskable interrupt.
// RQ11: Compare match sets sticky flag, maskable interrupt.
// RQ12: Software keeps compare above reload for PWM.
// RQ13: Software writes reload, then load and enable.
// RQ14: Capture: active edge copies counter, sets edge flag.
// RQ15: Capture modes: overflow sets, match clears output.
// RQ16: Capture modes: software never selects pin clock.
// RQ17: Capture-with-reset also clears counter and prescaler.
// RQ18: External load: active edge copies reload into counter.
// RQ19: Software keeps clock settings fixed while counting.
// RQ20: Writing 06h to status clears only overflow.
// RQ21: Second interrupt stays pending after first service.
// RQ22: Interrupt wakes core; pin clock works when stopped.
// RQ23: Overflow is the step from FFh to 00h.
// RQ24: Writing zero clears a flag; one leaves it.
// RQ25: Edge select: bit0 enables, bit1 chooses falling.
// RQ26: Mode field: auto, capture, capture-reset, ext load.
// RQ27: Interrupt when any flag and its enable set.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps

module auto_reload_pwm_capture_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic timer_in_pin,
  output logic pwm_out_pin,
  output logic timer_irq
);

  // ----------------------------------------------------------------------
  // Address decoding.
  // ----------------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  function automatic logic reg_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    reg_mapped = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) &&
      (idx == art_timer_pkg::IDX_MODE || idx == art_timer_pkg::IDX_STATUS ||
       idx == art_timer_pkg::IDX_CLK_EDGE ||
       idx == art_timer_pkg::IDX_RELOAD ||
       idx == art_timer_pkg::IDX_COMPARE || idx == art_timer_pkg::IDX_LOAD);
  endfunction : reg_mapped

  // Low bits that must all be one for a tap to pass a tick.
  function automatic logic [6:0] tap_mask(input logic [2:0] sel);
    tap_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction : tap_mask

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  art_timer_pkg::mode_ctrl_type mode_ctrl;
  art_timer_pkg::clk_cfg_type clk_cfg;
  logic [7:0] reload_capture_reg;
  logic [7:0] compare_reg;
  logic [7:0] up_counter;
  logic [6:0] prescaler_count;
  logic [2:0] flags;
  logic [1:0] div3_count;
  logic in_meta;
  logic in_sync;
  logic in_prev;
  logic pwm_state;
  logic [11:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane0_q;

  // ----------------------------------------------------------------------
  // Write channel: address and data are taken in either order.
  // ----------------------------------------------------------------------
  logic wr_go;
  logic wr_ok;
  logic [7:0] wr_idx;

  assign wr_go = !awready && !wready && !bvalid;
  assign wr_ok = wr_go && reg_mapped(aw_addr_q) && w_lane0_q;
  assign wr_idx = reg_index(aw_addr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr_q <= 12'h000;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_byte_q <= wdata[7:0];
      w_lane0_q <= wstrb[0];
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= art_timer_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= reg_mapped(aw_addr_q) ? art_timer_pkg::RESP_OKAY :
        art_timer_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic wr_mode;
  logic wr_status;
  logic wr_clk;
  logic wr_reload;
  logic wr_compare;
  logic win_wr;
  logic counter_load_bit_wr;

  assign wr_mode = wr_ok && wr_idx == art_timer_pkg::IDX_MODE;
  assign wr_status = wr_ok && wr_idx == art_timer_pkg::IDX_STATUS;
  assign wr_clk = wr_ok && wr_idx == art_timer_pkg::IDX_CLK_EDGE;
  assign wr_reload = wr_ok && wr_idx == art_timer_pkg::IDX_RELOAD;
  assign wr_compare = wr_ok && wr_idx == art_timer_pkg::IDX_COMPARE;
  assign win_wr = wr_ok && wr_idx == art_timer_pkg::IDX_LOAD;
  assign counter_load_bit_wr = wr_mode && w_byte_q[art_timer_pkg::COUNTER_LOAD_BIT_BIT];

  // ----------------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ctrl <= art_timer_pkg::MODE_CTRL_RESET;
    end else if (wr_mode) begin
      mode_ctrl <= w_byte_q[6:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_cfg <= art_timer_pkg::CLK_CFG_RESET;
    end else if (wr_clk) begin
      clk_cfg <= w_byte_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_reg <= art_timer_pkg::COUNT_ZERO;
    end else if (wr_compare) begin
      compare_reg <= w_byte_q;
    end
  end

  // ----------------------------------------------------------------------
  // Input pin synchroniser and clock sources.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      in_meta <= timer_in_pin;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || div3_count == art_timer_pkg::DIV3_LAST) begin
      div3_count <= 2'h0;
    end else begin
      div3_count <= div3_count + 2'h1;
    end
  end

  logic pin_rise;
  logic pin_fall;
  logic src_tick;
  logic pre_tick;
  logic cnt_tick;
  logic edge_evt;
  logic cap_evt;
  logic cap_rst_evt;
  logic ext_evt;
  logic any_load;
  logic ovf_evt;
  logic match_evt;
  logic [7:0] tick_value;
  logic [1:0] mode;

  assign pin_rise = in_sync && !in_prev;
  assign pin_fall = !in_sync && in_prev;
  assign mode = mode_ctrl.operating_mode_sel;

  always_comb begin
    unique case (clk_cfg.clock_src_sel) // [RQ2]
      art_timer_pkg::SRC_INT: src_tick = 1'b1;
      art_timer_pkg::SRC_DIV3: src_tick = div3_count == art_timer_pkg::DIV3_LAST;
      art_timer_pkg::SRC_PIN: src_tick = pin_rise;
      default: src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Event decoding.
  // ----------------------------------------------------------------------
  assign pre_tick = mode_ctrl.count_enable_bit && src_tick; // [RQ4]
  assign cnt_tick = pre_tick && ((prescaler_count |
    ~tap_mask(clk_cfg.prescale_sel)) == 7'h7f); // [RQ3]
  assign edge_evt = clk_cfg.edge_sel[0] &&
    (clk_cfg.edge_sel[1] ? pin_fall : pin_rise); // [RQ25]
  assign cap_evt = edge_evt && (mode == art_timer_pkg::MODE_CAPTURE ||
    mode == art_timer_pkg::MODE_CAP_RESET); // [RQ26]
  assign cap_rst_evt = edge_evt && mode == art_timer_pkg::MODE_CAP_RESET;
  assign ext_evt = edge_evt && mode == art_timer_pkg::MODE_EXT_LOAD;
  assign any_load = win_wr || counter_load_bit_wr || cap_rst_evt || ext_evt;
  assign ovf_evt = cnt_tick && !any_load &&
    up_counter == art_timer_pkg::COUNT_MAX; // [RQ23]
  assign tick_value = (up_counter != art_timer_pkg::COUNT_MAX) ?
    up_counter + 8'h01 : (mode == art_timer_pkg::MODE_AUTO) ?
    reload_capture_reg : art_timer_pkg::COUNT_ZERO; // [RQ8]
  assign match_evt = cnt_tick && !any_load && tick_value == compare_reg;

  // ----------------------------------------------------------------------
  // Counter and prescaler.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_counter <= art_timer_pkg::COUNT_ZERO; // [RQ5]
    end else if (win_wr) begin
      up_counter <= w_byte_q; // [RQ6]
    end else if (counter_load_bit_wr || ext_evt) begin
      up_counter <= reload_capture_reg; // [RQ18]
    end else if (cap_rst_evt) begin
      up_counter <= art_timer_pkg::COUNT_ZERO; // [RQ17]
    end else if (cnt_tick) begin
      up_counter <= tick_value; // [RQ1]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || any_load) begin
      prescaler_count <= art_timer_pkg::PRESCALE_ZERO; // [RQ7]
    end else if (pre_tick) begin
      prescaler_count <= prescaler_count + 7'h01;
    end
  end

  // A capture beats a software write landing in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_capture_reg <= art_timer_pkg::COUNT_ZERO;
    end else if (cap_evt) begin
      reload_capture_reg <= up_counter; // [RQ14]
    end else if (wr_reload) begin
      reload_capture_reg <= w_byte_q;
    end
  end

  // ----------------------------------------------------------------------
  // PWM waveform; an overflow wins over a match in the same tick.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_state <= 1'b0;
    end else if (ovf_evt) begin
      pwm_state <= 1'b1; // [RQ8] [RQ15]
    end else if (match_evt) begin
      pwm_state <= 1'b0; // [RQ9] [RQ15]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_out_pin <= 1'b0;
    end else begin
      pwm_out_pin <= pwm_state && mode_ctrl.pwm_en;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flags; a new event wins over a clear in the same cycle.
  // ----------------------------------------------------------------------
  logic [2:0] flag_set;
  logic [2:0] flag_irq_en;

  assign flag_set = {edge_evt, match_evt, ovf_evt};
  assign flag_irq_en = {mode_ctrl.edge_irq_en, mode_ctrl.compare_irq_en,
    mode_ctrl.overflow_irq_en};

  for (genvar i = 0; i < art_timer_pkg::FLAG_COUNT; i++) begin : g_flag
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flags[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flags[i] <= 1'b1; // [RQ10] [RQ11] [RQ14]
      end else if (wr_status && !w_byte_q[i]) begin
        flags[i] <= 1'b0; // [RQ20] [RQ24]
      end
    end
  end

  // The request stays high while any enabled flag is pending, so it also
  // serves as the wake request; the pin clock keeps ticking in stop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(flags & flag_irq_en); // [RQ21] [RQ22] [RQ27]
    end
  end

  // ----------------------------------------------------------------------
  // Read channel.
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    case (reg_index(araddr))
      art_timer_pkg::IDX_MODE: rd_byte = {1'b0, mode_ctrl};
      art_timer_pkg::IDX_STATUS: rd_byte = {5'h00, flags};
      art_timer_pkg::IDX_CLK_EDGE: rd_byte = clk_cfg;
      art_timer_pkg::IDX_RELOAD: rd_byte = reload_capture_reg;
      art_timer_pkg::IDX_COMPARE: rd_byte = compare_reg;
      art_timer_pkg::IDX_LOAD: rd_byte = up_counter; // [RQ6]
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= art_timer_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= reg_mapped(araddr) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      rresp <= reg_mapped(araddr) ? art_timer_pkg::RESP_OKAY :
        art_timer_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence s_plain_tick;
    cnt_tick && !any_load && up_counter != art_timer_pkg::COUNT_MAX;
  endsequence

  sequence s_auto_overflow;
    ovf_evt && mode == art_timer_pkg::MODE_AUTO;
  endsequence

  chk_count_step: assert property ( // [RQ1]
    @(posedge aclk) disable iff (!aresetn)
    s_plain_tick |=> up_counter == $past(up_counter) + 8'h01)
    else $error("counter did not step by one");

  chk_stop_freeze: assert property ( // [RQ4]
    @(posedge aclk) disable iff (!aresetn)
    !mode_ctrl.count_enable_bit && !any_load |=>
      $stable(up_counter) && $stable(prescaler_count))
    else $error("stopped timer moved");

  chk_reset_clear: assert property ( // [RQ5]
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> up_counter == art_timer_pkg::COUNT_ZERO)
    else $error("counter not zero after reset");

  chk_window_load: assert property ( // [RQ6] [RQ7]
    @(posedge aclk) disable iff (!aresetn)
    win_wr |=> up_counter == $past(w_byte_q) &&
      prescaler_count == art_timer_pkg::PRESCALE_ZERO)
    else $error("load window write not applied");

  chk_auto_reload: assert property ( // [RQ8]
    @(posedge aclk) disable iff (!aresetn)
    s_auto_overflow |=> up_counter == $past(reload_capture_reg) ##1
      pwm_out_pin == mode_ctrl.pwm_en)
    else $error("overflow did not reload or set output");

  chk_match_low: assert property ( // [RQ9] [RQ11] [RQ15]
    @(posedge aclk) disable iff (!aresetn)
    match_evt && !ovf_evt |=> !pwm_state && flags[art_timer_pkg::FLAG_CMP]
      ##1 !pwm_out_pin)
    else $error("match did not clear output or set flag");

  chk_ovf_sticky: assert property ( // [RQ10]
    @(posedge aclk) disable iff (!aresetn)
    ovf_evt ##1 !wr_status[*2] |-> flags[art_timer_pkg::FLAG_OVF])
    else $error("overflow flag not held");

  chk_capture: assert property ( // [RQ14]
    @(posedge aclk) disable iff (!aresetn)
    cap_evt |=> reload_capture_reg == $past(up_counter) &&
      flags[art_timer_pkg::FLAG_EDGE])
    else $error("capture not taken");

  chk_cap_reset: assert property ( // [RQ17]
    @(posedge aclk) disable iff (!aresetn)
    cap_rst_evt && !win_wr && !counter_load_bit_wr |=>
      up_counter == art_timer_pkg::COUNT_ZERO &&
      prescaler_count == art_timer_pkg::PRESCALE_ZERO)
    else $error("capture reset did not clear count");

  chk_ext_load: assert property ( // [RQ18]
    @(posedge aclk) disable iff (!aresetn)
    ext_evt && !win_wr |=> up_counter == $past(reload_capture_reg))
    else $error("external load not applied");

  chk_status_clear: assert property ( // [RQ20]
    @(posedge aclk) disable iff (!aresetn)
    wr_status && w_byte_q == 8'h06 && !ovf_evt &&
      flags[art_timer_pkg::FLAG_EDGE] |=>
      !flags[art_timer_pkg::FLAG_OVF] && flags[art_timer_pkg::FLAG_EDGE])
    else $error("status write disturbed edge flag");

  chk_irq_level: assert property ( // [RQ27]
    @(posedge aclk) disable iff (!aresetn)
    ##1 timer_irq == $past(|(flags & flag_irq_en)))
    else $error("interrupt does not follow flags");

endmodule : auto_reload_pwm_capture_timer

// [pkg/art_timer_pkg.sv]
// Package with register map, field layouts and codes of the reload timer.
package art_timer_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_MODE = 8'hd5;
  localparam logic [7:0] IDX_STATUS = 8'hd6;
  localparam logic [7:0] IDX_CLK_EDGE = 8'hd7;
  localparam logic [7:0] IDX_RELOAD = 8'hd9;
  localparam logic [7:0] IDX_COMPARE = 8'hda;
  localparam logic [7:0] IDX_LOAD = 8'hdb;

  // ----------------------------------------------------------------------
  // Field positions, codes and reset values.
  // ----------------------------------------------------------------------
  localparam int COUNTER_LOAD_BIT_BIT = 7;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP = 1;
  localparam int FLAG_EDGE = 2;
  localparam int FLAG_COUNT = 3;

  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_CAP_RESET = 2'h2;
  localparam logic [1:0] MODE_EXT_LOAD = 2'h3;

  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_DIV3 = 2'h1;
  localparam logic [1:0] SRC_PIN = 2'h2;
  localparam logic [1:0] DIV3_LAST = 2'h2;

  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [6:0] PRESCALE_ZERO = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode control register, bits 6..0; bit 7 is the write-only load bit.
  typedef struct packed {
    logic count_enable_bit;
    logic pwm_en;
    logic edge_irq_en;
    logic compare_irq_en;
    logic overflow_irq_en;
    logic [1:0] operating_mode_sel;
  } mode_ctrl_type;

  // Clock and edge configuration register.
  typedef struct packed {
    logic [2:0] prescale_sel;
    logic reserved;
    logic [1:0] edge_sel;
    logic [1:0] clock_src_sel;
  } clk_cfg_type;

  localparam mode_ctrl_type MODE_CTRL_RESET = 7'h00;
  localparam clk_cfg_type CLK_CFG_RESET = 8'h00;

endpackage : art_timer_pkg

// [verif/pin_partner_model.sv]
// Partner model: edge source on the timer input and load on the PWM output.
`timescale 1ns/1ps

module pin_partner_model (
  input wire logic aclk,
  input wire logic pwm_out_pin,
  output logic timer_in_pin
);
  int run_len = 0;
  int high_len = 0;
  int low_len = 0;
  logic last_pwm = 1'b0;

  initial begin
    timer_in_pin = 1'b0;
  end

  // Each level is held long enough to pass the input synchroniser.
  task automatic drive_level(input logic lvl);
    @(posedge aclk);
    timer_in_pin <= lvl;
    repeat (6) @(posedge aclk);
  endtask : drive_level

  // The pin rests low between pulses, so it never runs as a free clock.
  task automatic pulse_train(input int n);
    for (int i = 0; i < n; i++) begin
      drive_level(1'b1);
      drive_level(1'b0);
    end
  endtask : pulse_train

  // The load records how long each completed phase of the output lasted.
  always @(posedge aclk) begin
    if (pwm_out_pin !== last_pwm) begin
      if (last_pwm === 1'b1) high_len <= run_len;
      else low_len <= run_len;
      run_len <= 1;
    end else begin
      run_len <= run_len + 1;
    end
    last_pwm <= pwm_out_pin;
  end
endmodule : pin_partner_model

// [verif/auto_reload_pwm_capture_timer_bench.sv]
// Self-checking bench of the reload timer with its pin partner.
`timescale 1ns/1ps

module auto_reload_pwm_capture_timer_bench;
  // --------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------
  localparam logic [7:0] R_MODE = art_timer_pkg::IDX_MODE;
  localparam logic [7:0] R_STAT = art_timer_pkg::IDX_STATUS;
  localparam logic [7:0] R_CFG = art_timer_pkg::IDX_CLK_EDGE;
  localparam logic [7:0] R_RLD = art_timer_pkg::IDX_RELOAD;
  localparam logic [7:0] R_CMP = art_timer_pkg::IDX_COMPARE;
  localparam logic [7:0] R_LOAD = art_timer_pkg::IDX_LOAD;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h1;
  logic [11:0] addr_xor = 12'h000;
  logic [31:0] rword;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic pwm_out_pin, timer_irq, timer_in_pin;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata;
  logic [7:0] rv;
  int err_total = 0;
  int samples_checked = 0;

  auto_reload_pwm_capture_timer u_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .timer_in_pin(timer_in_pin),
    .pwm_out_pin(pwm_out_pin),
    .timer_irq(timer_irq)
  );

  pin_partner_model u_pin (
    .aclk(aclk),
    .pwm_out_pin(pwm_out_pin),
    .timer_in_pin(timer_in_pin)
  );

  initial begin
    forever #25 aclk = ~aclk;
  end

  // --------------------------------------------------------------------
  // Bus cycles and comparisons
  // --------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic hang(input string what);
    err_total++;
    $display("[ERR] %0t timeout on %s", $time, what);
    tally_and_finish();
  endtask : hang

  task automatic check_rng(input logic [7:0] got, input logic [7:0] lo,
                           input logic [7:0] hi, input string what);
    samples_checked++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      err_total++;
      $display("[ERR] %0t %s got %h", $time, what, got);
    end
  endtask : check_rng

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0} ^ addr_xor;
    wdata <= {~val, ~val, ~val, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 40) hang("write");
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0} ^ addr_xor;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rv = rdata[7:0];
    rword = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 40) hang("read");
  endtask : rd_reg

  task automatic expect_reg(input logic [7:0] idx, input logic [7:0] lo,
                            input logic [7:0] hi, input string what);
    rd_reg(idx);
    check_rng(rv, lo, hi, what);
  endtask : expect_reg

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset;
    check_rng({7'h00, pwm_out_pin}, 8'h00, 8'h00, "pin idle");
    expect_reg(R_LOAD, 8'h00, 8'h00, "count at reset");
    expect_reg(R_MODE, 8'h00, 8'h00, "mode at reset");
    rd_reg(8'h00);
    check_rng({6'h00, rsp}, {6'h00, art_timer_pkg::RESP_SLVERR},
              {6'h00, art_timer_pkg::RESP_SLVERR}, "unmapped");
  endtask : t_reset

  // Misaligned or out-of-range addresses and a cleared strobe change nothing.
  task automatic t_refuse;
    wr_reg(R_CMP, 8'h33);
    check_rng({6'h00, rsp}, 8'h00, 8'h00, "write okay");
    addr_xor <= 12'h801;
    wr_reg(R_CMP, 8'h44);
    check_rng({6'h00, rsp}, {6'h00, art_timer_pkg::RESP_SLVERR},
              {6'h00, art_timer_pkg::RESP_SLVERR}, "bad write addr");
    addr_xor <= 12'h402;
    rd_reg(R_CMP);
    check_rng({6'h00, rsp}, {6'h00, art_timer_pkg::RESP_SLVERR},
              {6'h00, art_timer_pkg::RESP_SLVERR}, "bad read addr");
    check_rng({7'h00, |rword}, 8'h00, 8'h00, "bad read data");
    addr_xor <= 12'h000;
    wstrb <= 4'h0;
    wr_reg(R_CMP, 8'h55);
    wstrb <= 4'h1;
    expect_reg(R_CMP, 8'h33, 8'h33, "refused writes");
    check_rng(rword[15:8], 8'h00, 8'h00, "upper data");
  endtask : t_refuse

  task automatic t_freeze;
    wr_reg(R_LOAD, 8'h40);
    repeat (20) @(posedge aclk);
    expect_reg(R_LOAD, 8'h40, 8'h40, "frozen count");
  endtask : t_freeze

  task automatic t_rates;
    logic [7:0] cfg [3] = '{8'h60, 8'h01, 8'h21};
    logic [7:0] lo [3] = '{8'h0c, 8'h20, 8'h10};
    for (int i = 0; i < 3; i++) begin
      wr_reg(R_CFG, cfg[i]);
      wr_reg(R_RLD, 8'h00);
      wr_reg(R_MODE, 8'hc0);
      repeat (96) @(posedge aclk);
      wr_reg(R_MODE, 8'h00);
      expect_reg(R_LOAD, lo[i], lo[i] + 8'h02, "rate");
    end
    wr_reg(R_CFG, 8'h02);
    wr_reg(R_MODE, 8'hc0);
    u_pin.pulse_train(5);
    wr_reg(R_MODE, 8'h00);
    expect_reg(R_LOAD, 8'h05, 8'h05, "pin clock");
  endtask : t_rates

  task automatic t_pwm;
    wr_reg(R_CFG, 8'h00);
    wr_reg(R_RLD, 8'hf0);
    wr_reg(R_CMP, 8'hf8);
    wr_reg(R_MODE, 8'he4);
    repeat (80) @(posedge aclk);
    check_rng(u_pin.high_len[7:0], 8'h08, 8'h08, "high");
    check_rng(u_pin.low_len[7:0], 8'h08, 8'h08, "low");
    check_rng({7'h00, timer_irq}, 8'h01, 8'h01, "irq");
    wr_reg(R_MODE, 8'h04);
    expect_reg(R_STAT, 8'h03, 8'h03, "flags");
    wr_reg(R_STAT, 8'h06);
    expect_reg(R_STAT, 8'h02, 8'h02, "ovf only");
    wr_reg(R_STAT, 8'hff);
    expect_reg(R_STAT, 8'h02, 8'h02, "ones");
    check_rng({7'h00, timer_irq}, 8'h00, 8'h00, "masked");
    wr_reg(R_MODE, 8'h08);
    repeat (3) @(posedge aclk);
    check_rng({7'h00, timer_irq}, 8'h01, 8'h01, "cmp irq");
    wr_reg(R_STAT, 8'h00);
    expect_reg(R_STAT, 8'h00, 8'h00, "cleared");
  endtask : t_pwm

  task automatic t_edges;
    wr_reg(R_MODE, 8'h11);
    u_pin.pulse_train(1);
    expect_reg(R_STAT, 8'h00, 8'h00, "edge off");
    wr_reg(R_CFG, 8'h0c);
    u_pin.drive_level(1'b1);
    expect_reg(R_STAT, 8'h00, 8'h00, "rise");
    u_pin.drive_level(1'b0);
    expect_reg(R_STAT, 8'h04, 8'h04, "fall");
    check_rng({7'h00, timer_irq}, 8'h01, 8'h01, "edge irq");
    wr_reg(R_STAT, 8'h06);
    expect_reg(R_STAT, 8'h04, 8'h04, "edge kept");
    wr_reg(R_STAT, 8'h00);
    wr_reg(R_CFG, 8'h04);
    wr_reg(R_MODE, 8'h51);
    wr_reg(R_LOAD, 8'h20);
    u_pin.drive_level(1'b1);
    expect_reg(R_RLD, 8'h21, 8'h30, "capture");
    u_pin.drive_level(1'b0);
    wr_reg(R_MODE, 8'h52);
    wr_reg(R_LOAD, 8'ha0);
    u_pin.drive_level(1'b1);
    expect_reg(R_LOAD, 8'h00, 8'h10, "reset");
    expect_reg(R_RLD, 8'ha1, 8'hb0, "capture");
    u_pin.drive_level(1'b0);
    wr_reg(R_MODE, 8'h03);
    wr_reg(R_RLD, 8'h5a);
    wr_reg(R_LOAD, 8'h11);
    u_pin.drive_level(1'b1);
    expect_reg(R_LOAD, 8'h5a, 8'h5a, "ext load");
    u_pin.drive_level(1'b0);
  endtask : t_edges

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_refuse();
    t_freeze();
    t_rates();
    t_pwm();
    t_edges();
    tally_and_finish();
  end
endmodule : auto_reload_pwm_capture_timer_bench
